//--- pmc_pkg.sv
package pmc_pkg;
	// ======================================================
	// register map, byte addresses on the apb bus
	localparam logic [7:0] OFF_DS_CONTROL = 8'h00;
	localparam logic [7:0] OFF_DS_WAKE = 8'h04;
	localparam logic [7:0] OFF_GP_ZERO = 8'h08;
	localparam logic [7:0] OFF_GP_ONE = 8'h0C;
	localparam logic [7:0] OFF_RESET_CONTROL = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;

	// ======================================================
	// guarded register indices inside the double-write store
	localparam int GUARD_REGS = 4;
	localparam logic [1:0] GIDX_DS_CONTROL = 2'h0;
	localparam logic [1:0] GIDX_DS_WAKE = 2'h1;
	localparam logic [1:0] GIDX_GP_ZERO = 2'h2;
	localparam logic [1:0] GIDX_GP_ONE = 2'h3;

	// ======================================================
	// field positions and reset values
	localparam int DEEP_ENABLE_BIT = 15;
	localparam int DS_LOW_BIT = 0;
	localparam int RET_ENABLE_BIT = 12;
	localparam int ST_LVR_BIT = 4;
	localparam int ST_HOLD_BIT = 5;
	localparam int ST_DEFER_BIT = 6;
	localparam int ST_MODE_LSB = 0;
	localparam logic [15:0] GUARD_RESET = 16'h0000;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
	localparam logic [15:0] HALF_ZERO = 16'h0000;

	// ======================================================
	// power modes of the sequencer
	typedef enum logic [3:0] {
		ST_RUN,
		ST_ENTER,
		ST_IDLE,
		ST_SLEEP,
		ST_RET_SLEEP,
		ST_DEEP,
		ST_RET_DEEP,
		ST_BATTERY,
		ST_WAKE
	} pmode_t;
endpackage

//--- guard_if.sv
`timescale 1ns/1ps
// write path into the double-write store and its register contents
interface guard_if;
	import pmc_pkg::*;
	logic wr_valid;
	logic [1:0] wr_idx;
	logic [15:0] wr_data;
	logic pend_valid;
	logic [15:0] val [GUARD_REGS];
	modport ctrl (output wr_valid, output wr_idx, output wr_data,
		input pend_valid, input val);
	modport store (input wr_valid, input wr_idx, input wr_data,
		output pend_valid, output val);
endinterface

//--- guarded_regs.sv
`timescale 1ns/1ps
module guarded_regs
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	guard_if.store g
);
	logic pend_valid;
	logic next_pend_valid;
	logic [1:0] pend_idx;
	logic [1:0] next_pend_idx;
	logic [15:0] pend_data;
	logic [15:0] next_pend_data;
	logic commit;

	// ======================================================
	// write tracking: the first write is only remembered
	always_comb begin
		commit = g.wr_valid && pend_valid && (pend_idx == g.wr_idx)
			&& (pend_data == g.wr_data);
		next_pend_valid = pend_valid;
		next_pend_idx = pend_idx;
		next_pend_data = pend_data;
		if (g.wr_valid) begin
			// a differing write restarts the pair instead of committing
			next_pend_valid = !commit;
			next_pend_idx = g.wr_idx;
			next_pend_data = g.wr_data;
		end
	end

	// tracking starts empty after power-on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_valid <= 1'b0;
			pend_idx <= GIDX_DS_CONTROL;
			pend_data <= GUARD_RESET;
		end else begin
			pend_valid <= next_pend_valid;
			pend_idx <= next_pend_idx;
			pend_data <= next_pend_data;
		end
	end

	assign g.pend_valid = pend_valid;

	// ======================================================
	// storage: only power-on clears it, no power mode touches it
	for (genvar i = 0; i < GUARD_REGS; i++) begin : g_entry
		logic [15:0] val;
		logic [15:0] next_val;
		always_comb begin
			next_val = val;
			if (commit && (g.wr_idx == 2'(i))) begin
				next_val = g.wr_data;
			end
		end
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				val <= GUARD_RESET;
			end else begin
				val <= next_val;
			end
		end
		assign g.val[i] = val;
	end
endmodule

//--- power_mode_controller.sv
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module power_mode_controller
	import pmc_pkg::*;
(
	input wire logic REF_CLK_IN,
	input wire logic RESET_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic POWER_SAVE_INSTRUCTION_IN,
	input wire logic POWER_SAVE_SLEEP_IN,
	input wire logic LVR_CONFIG_IN,
	input wire logic IRQ_WAKE_IN,
	input wire logic EXT_INT_ZERO_IN,
	input wire logic RESET_EVENT_IN,
	input wire logic MASTER_CLEAR_IN,
	input wire logic RTC_ALARM_IN,
	input wire logic WDT_TIMEOUT_IN,
	input wire logic DEEP_WDT_TIMEOUT_IN,
	input wire logic VDD_LOST_IN,
	output logic CPU_CLK_EN_OUT,
	output logic SYS_CLK_EN_OUT,
	output logic PERIPH_CLK_EN_OUT,
	output logic LOW_POWER_RC_EN_OUT,
	output logic RAM_PWR_OUT,
	output logic FLASH_PWR_OUT,
	output logic LVR_ENGAGE_OUT,
	output logic IRQ_HOLD_OUT,
	output logic WDT_CLEAR_OUT,
	output logic WAKE_OUT,
	output logic RESUME_RESET_OUT,
	output logic DEEP_WDT_SELECT_OUT,
	output logic [3:0] MODE_OUT
);
	guard_if gif ();

	guarded_regs u_guard (
		.clk(REF_CLK_IN),
		.rst(RESET_IN),
		.g(gif.store)
	);

	// ======================================================
	// apb slave
	logic access;
	logic hit_guard;
	logic hit_any;
	logic [1:0] guard_idx;
	logic reten;
	logic next_reten;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic deep_sleep_enable;
	logic ret_ok;
	pmode_t state;

	assign deep_sleep_enable = gif.val[GIDX_DS_CONTROL][DEEP_ENABLE_BIT];
	// the config strap wins: at 1 the retention bit is ignored
	assign ret_ok = reten && !LVR_CONFIG_IN;

	// address decode and read mux; one wait state before pready
	always_comb begin
		access = PSEL_IN && PENABLE_IN && PREADY_OUT;
		hit_guard = 1'b1;
		guard_idx = GIDX_DS_CONTROL;
		case (PADDR_IN)
			OFF_DS_CONTROL: guard_idx = GIDX_DS_CONTROL;
			OFF_DS_WAKE: guard_idx = GIDX_DS_WAKE;
			OFF_GP_ZERO: guard_idx = GIDX_GP_ZERO;
			OFF_GP_ONE: guard_idx = GIDX_GP_ONE;
			default: hit_guard = 1'b0;
		endcase
		hit_any = hit_guard || (PADDR_IN == OFF_RESET_CONTROL)
			|| (PADDR_IN == OFF_STATUS);
		next_pready = PSEL_IN && PENABLE_IN && !PREADY_OUT;
		next_pslverr = next_pready && !hit_any;
		next_prdata = RDATA_ZERO;
		if (next_pready && !PWRITE_IN) begin
			if (hit_guard) begin
				next_prdata[15:0] = gif.val[guard_idx];
			end else if (PADDR_IN == OFF_RESET_CONTROL) begin
				next_prdata[RET_ENABLE_BIT] = reten;
			end else if (PADDR_IN == OFF_STATUS) begin
				next_prdata[ST_MODE_LSB +: 4] = 4'(state);
				next_prdata[ST_LVR_BIT] = LVR_ENGAGE_OUT;
				next_prdata[ST_HOLD_BIT] = IRQ_HOLD_OUT;
				next_prdata[ST_DEFER_BIT] = gif.pend_valid;
			end
		end
		// writes take effect only at the edge that completes the access
		gif.wr_valid = access && PWRITE_IN && hit_guard;
		gif.wr_idx = guard_idx;
		gif.wr_data = PWDATA_IN[15:0];
		next_reten = reten;
		if (access && PWRITE_IN && (PADDR_IN == OFF_RESET_CONTROL)) begin
			next_reten = PWDATA_IN[RET_ENABLE_BIT];
		end
	end

	// bus answer and the ordinary retention bit
	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			PRDATA_OUT <= RDATA_ZERO;
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			reten <= 1'b0;
		end else begin
			PRDATA_OUT <= next_prdata;
			PREADY_OUT <= next_pready;
			PSLVERR_OUT <= next_pslverr;
			reten <= next_reten;
		end
	end

	// ======================================================
	// mode sequencer
	pmode_t next_state;
	pmode_t target;
	pmode_t next_target;
	logic def_irq;
	logic next_def_irq;
	logic def_int_zero;
	logic next_def_int_zero;
	logic resume_reset;
	logic next_resume_reset;
	logic any_reset;
	logic wake_gen;
	logic wake_deep;
	logic wake_ret_deep;
	logic wake_now;
	logic wake_rst;

	// reset sources other than power-on, which is RESET_IN itself
	assign any_reset = RESET_EVENT_IN || MASTER_CLEAR_IN;

	// wake conditions per mode; deferred interrupts count as arriving
	always_comb begin
		wake_gen = IRQ_WAKE_IN || def_irq || def_int_zero || EXT_INT_ZERO_IN
			|| any_reset || WDT_TIMEOUT_IN;
		wake_ret_deep = EXT_INT_ZERO_IN || def_int_zero || any_reset
			|| RTC_ALARM_IN || DEEP_WDT_TIMEOUT_IN;
		wake_deep = EXT_INT_ZERO_IN || def_int_zero || any_reset
			|| RTC_ALARM_IN || DEEP_WDT_TIMEOUT_IN;
		wake_now = 1'b0;
		wake_rst = any_reset;
		case (state)
			ST_IDLE, ST_SLEEP, ST_RET_SLEEP: wake_now = wake_gen;
			ST_RET_DEEP: wake_now = wake_ret_deep;
			ST_DEEP: begin
				wake_now = wake_deep;
				// ram was lost, so every exit restarts at reset
				wake_rst = 1'b1;
			end
			ST_BATTERY: begin
				wake_now = !VDD_LOST_IN;
				wake_rst = 1'b1;
			end
			default: wake_now = 1'b0;
		endcase
	end

	// state and deferral bookkeeping
	always_comb begin
		next_state = state;
		next_target = target;
		next_def_irq = def_irq;
		next_def_int_zero = def_int_zero;
		next_resume_reset = 1'b0;
		case (state)
			ST_RUN: begin
				if (POWER_SAVE_INSTRUCTION_IN) begin
					next_state = ST_ENTER;
					if (!POWER_SAVE_SLEEP_IN) begin
						next_target = ST_IDLE;
					end else if (deep_sleep_enable && ret_ok) begin
						next_target = ST_RET_DEEP;
					end else if (deep_sleep_enable) begin
						next_target = ST_DEEP;
					end else if (ret_ok) begin
						next_target = ST_RET_SLEEP;
					end else begin
						next_target = ST_SLEEP;
					end
				end
			end
			ST_ENTER: begin
				// an interrupt here is kept, not lost; interrupt zero wakes any target later, the others only idle and sleep
				next_def_irq = def_irq || IRQ_WAKE_IN;
				next_def_int_zero = def_int_zero || EXT_INT_ZERO_IN;
				next_state = target;
			end
			ST_IDLE, ST_SLEEP, ST_RET_SLEEP, ST_DEEP, ST_RET_DEEP,
			ST_BATTERY: begin
				if (wake_now) begin
					next_state = ST_WAKE;
					next_resume_reset = wake_rst;
					next_def_irq = 1'b0;
					next_def_int_zero = 1'b0;
				end
			end
			ST_WAKE: next_state = ST_RUN;
			default: next_state = ST_RUN;
		endcase
		// supply loss overrides whatever the core was doing
		if (VDD_LOST_IN && state != ST_BATTERY) begin
			next_state = ST_BATTERY;
		end
		// an event that lands in the entry cycle is deferred; one on the clearing cycle is dropped
		if (state == ST_ENTER) begin
			next_def_irq = def_irq || IRQ_WAKE_IN;
			next_def_int_zero = def_int_zero || EXT_INT_ZERO_IN;
		end
	end

	// sequencer registers; power-on always lands in run
	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state <= ST_RUN;
			target <= ST_IDLE;
			def_irq <= 1'b0;
			def_int_zero <= 1'b0;
			resume_reset <= 1'b0;
		end else begin
			state <= next_state;
			target <= next_target;
			def_irq <= next_def_irq;
			def_int_zero <= next_def_int_zero;
			resume_reset <= next_resume_reset;
		end
	end

	// ======================================================
	// power and clock controls, decoded from the next state
	logic n_cpu;
	logic n_sys;
	logic n_periph;
	logic n_low_power_rc_osc;
	logic n_ram;
	logic n_flash;
	logic n_lvr;
	logic n_hold;
	logic n_wdtclr;
	logic n_wake;
	logic n_deep_sleep_watchdog;

	always_comb begin
		n_cpu = 1'b0;
		n_sys = 1'b0;
		n_periph = 1'b0;
		n_low_power_rc_osc = 1'b1;
		n_ram = 1'b1;
		n_flash = 1'b1;
		n_lvr = 1'b0;
		n_deep_sleep_watchdog = 1'b0;
		n_hold = (next_state == ST_ENTER);
		// pulse on entry so the watchdog restarts its full period
		n_wdtclr = (state == ST_RUN) && (next_state == ST_ENTER);
		n_wake = (next_state == ST_WAKE);
		case (next_state)
			ST_RUN, ST_ENTER, ST_WAKE: begin
				n_cpu = 1'b1;
				n_sys = 1'b1;
				n_periph = 1'b1;
			end
			ST_IDLE: begin
				// stop-in-idle is left to each peripheral
				n_sys = 1'b1;
				n_periph = 1'b1;
			end
			ST_SLEEP: n_sys = 1'b0;
			ST_RET_SLEEP: begin
				n_lvr = 1'b1;
				n_ram = 1'b1;
			end
			ST_RET_DEEP: begin
				n_lvr = 1'b1;
				n_ram = 1'b1;
				n_flash = 1'b0;
				n_deep_sleep_watchdog = 1'b1;
			end
			ST_DEEP: begin
				n_ram = 1'b0;
				n_flash = 1'b0;
				n_deep_sleep_watchdog = 1'b1;
			end
			ST_BATTERY: begin
				n_ram = 1'b0;
				n_flash = 1'b0;
				n_deep_sleep_watchdog = 1'b1;
			end
			default: n_cpu = 1'b1;
		endcase
	end

	// every control output comes from a flop; power-on looks like run
	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			CPU_CLK_EN_OUT <= 1'b1;
			SYS_CLK_EN_OUT <= 1'b1;
			PERIPH_CLK_EN_OUT <= 1'b1;
			LOW_POWER_RC_EN_OUT <= 1'b1;
			RAM_PWR_OUT <= 1'b1;
			FLASH_PWR_OUT <= 1'b1;
			LVR_ENGAGE_OUT <= 1'b0;
			IRQ_HOLD_OUT <= 1'b0;
			WDT_CLEAR_OUT <= 1'b0;
			WAKE_OUT <= 1'b0;
			RESUME_RESET_OUT <= 1'b0;
			DEEP_WDT_SELECT_OUT <= 1'b0;
			MODE_OUT <= 4'(ST_RUN);
		end else begin
			CPU_CLK_EN_OUT <= n_cpu;
			SYS_CLK_EN_OUT <= n_sys;
			PERIPH_CLK_EN_OUT <= n_periph;
			LOW_POWER_RC_EN_OUT <= n_low_power_rc_osc;
			RAM_PWR_OUT <= n_ram;
			FLASH_PWR_OUT <= n_flash;
			LVR_ENGAGE_OUT <= n_lvr;
			IRQ_HOLD_OUT <= n_hold;
			WDT_CLEAR_OUT <= n_wdtclr;
			WAKE_OUT <= n_wake;
			RESUME_RESET_OUT <= next_resume_reset;
			DEEP_WDT_SELECT_OUT <= n_deep_sleep_watchdog;
			MODE_OUT <= 4'(next_state);
		end
	end
endmodule

//--- cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
	input wire logic clk_in,
	output logic instr_out,
	output logic sleep_arg_out
);
	// ======================================================
	// instruction strobe
	initial begin
		instr_out = 1'b0;
		sleep_arg_out = 1'b0;
	end

	// one strobe per instruction, argument only valid beside it
	task issue(input logic arg);
		@(posedge clk_in);
		instr_out <= 1'b1;
		sleep_arg_out <= arg;
		@(posedge clk_in);
		instr_out <= 1'b0;
		sleep_arg_out <= ~arg; // stale argument must not be trusted
	endtask
endmodule

//--- power_mode_controller_props.sv
`timescale 1ns/1ps
module mode_checker (
	input wire logic REF_CLK_IN,
	input wire logic RESET_IN,
	input wire logic POWER_SAVE_INSTRUCTION_IN,
	input wire logic IRQ_WAKE_IN,
	input wire logic EXT_INT_ZERO_IN,
	input wire logic RESET_EVENT_IN,
	input wire logic MASTER_CLEAR_IN,
	input wire logic RTC_ALARM_IN,
	input wire logic DEEP_WDT_TIMEOUT_IN,
	input wire logic CPU_CLK_EN_OUT,
	input wire logic SYS_CLK_EN_OUT,
	input wire logic PERIPH_CLK_EN_OUT,
	input wire logic LOW_POWER_RC_EN_OUT,
	input wire logic RAM_PWR_OUT,
	input wire logic FLASH_PWR_OUT,
	input wire logic LVR_ENGAGE_OUT,
	input wire logic IRQ_HOLD_OUT,
	input wire logic WDT_CLEAR_OUT,
	input wire logic WAKE_OUT,
	input wire logic RESUME_RESET_OUT,
	input wire logic DEEP_WDT_SELECT_OUT,
	input wire logic [3:0] MODE_OUT
);
	// ======================================================
	// single clock domain, power-on reset disables all checks
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RESET_IN);

	chk_entry_step: assert property (
		POWER_SAVE_INSTRUCTION_IN && MODE_OUT == 4'h0 |=> MODE_OUT == 4'h1
		&& IRQ_HOLD_OUT
		&& WDT_CLEAR_OUT ##1 MODE_OUT inside {[4'h2:4'h6]})
		else $error("entry sequence wrong");
	chk_idle_gating: assert property (
		MODE_OUT == 4'h2 |-> !CPU_CLK_EN_OUT && SYS_CLK_EN_OUT
		&& PERIPH_CLK_EN_OUT) else $error("idle gating wrong");
	chk_sleep_stops: assert property (
		MODE_OUT inside {4'h3, 4'h4} |-> LOW_POWER_RC_EN_OUT && !(CPU_CLK_EN_OUT
		|| SYS_CLK_EN_OUT || PERIPH_CLK_EN_OUT))
		else $error("sleep clocks running");
	chk_deep_power: assert property (
		MODE_OUT inside {4'h5, 4'h6} |-> !FLASH_PWR_OUT && !SYS_CLK_EN_OUT
		&& RAM_PWR_OUT == (MODE_OUT == 4'h6))
		else $error("deep power wrong");
	chk_lvr_modes: assert property (
		LVR_ENGAGE_OUT == (MODE_OUT inside {4'h4, 4'h6}))
		else $error("regulator outside retention");
	chk_watchdog_src: assert property (
		MODE_OUT inside {[4'h2:4'h6]} |->
		DEEP_WDT_SELECT_OUT == (MODE_OUT > 4'h4))
		else $error("watchdog source wrong");
	chk_wake_pulse: assert property (
		$rose(WAKE_OUT) |-> MODE_OUT == 4'h8 && CPU_CLK_EN_OUT
		##1 MODE_OUT == 4'h0 && !WAKE_OUT) else $error("wake pulse wrong");
	chk_retdeep_irq: assert property (
		MODE_OUT == 4'h6 && $stable(MODE_OUT) && IRQ_WAKE_IN
		&& !(EXT_INT_ZERO_IN || MASTER_CLEAR_IN || RESET_EVENT_IN
		|| RTC_ALARM_IN || DEEP_WDT_TIMEOUT_IN) |=> MODE_OUT == 4'h6)
		else $error("interrupt woke retention deep");
	chk_deep_resume: assert property (
		WAKE_OUT && $past(MODE_OUT) == 4'h5 |-> RESUME_RESET_OUT)
		else $error("deep wake not at reset vector");
	chk_retdeep_resume: assert property (
		WAKE_OUT && $past(MODE_OUT) == 4'h6 |-> RESUME_RESET_OUT ==
		($past(MASTER_CLEAR_IN) || $past(RESET_EVENT_IN)))
		else $error("retention deep resume wrong");

	// main scenarios reached
	cov_ret_deep: cover property (MODE_OUT == 4'h6);
	cov_ret_sleep: cover property (MODE_OUT == 4'h4 && LVR_ENGAGE_OUT);
	cov_reset_wake: cover property (WAKE_OUT && RESUME_RESET_OUT);
endmodule

bind power_mode_controller mode_checker mode_checker_i (.REF_CLK_IN,
	.RESET_IN, .POWER_SAVE_INSTRUCTION_IN, .IRQ_WAKE_IN, .EXT_INT_ZERO_IN,
	.RESET_EVENT_IN, .MASTER_CLEAR_IN, .RTC_ALARM_IN, .DEEP_WDT_TIMEOUT_IN,
	.CPU_CLK_EN_OUT, .SYS_CLK_EN_OUT, .PERIPH_CLK_EN_OUT,
	.LOW_POWER_RC_EN_OUT, .RAM_PWR_OUT, .FLASH_PWR_OUT, .LVR_ENGAGE_OUT,
	.IRQ_HOLD_OUT, .WDT_CLEAR_OUT, .WAKE_OUT, .RESUME_RESET_OUT,
	.DEEP_WDT_SELECT_OUT, .MODE_OUT);

//--- power_mode_controller_test.sv
`timescale 1ns/1ps
module power_mode_controller_test;
	import pmc_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic psave, sleep_arg, lvr_cfg, vdd_lost, wake, resume;
	logic cpu_en, sys_en, ram_pwr, lvr_on, deep_sleep_watchdog_sel;
	logic [6:0] wk;
	logic [3:0] mode;
	int error_cnt, checks_done, n;

	// ======================================================
	// device, cpu model and clock
	power_mode_controller power_mode_controller_i (.REF_CLK_IN(clk),
		.RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.POWER_SAVE_INSTRUCTION_IN(psave),
		.POWER_SAVE_SLEEP_IN(sleep_arg),
		.LVR_CONFIG_IN(lvr_cfg), .IRQ_WAKE_IN(wk[0]),
		.EXT_INT_ZERO_IN(wk[1]), .RESET_EVENT_IN(wk[2]),
		.MASTER_CLEAR_IN(wk[3]), .RTC_ALARM_IN(wk[4]),
		.WDT_TIMEOUT_IN(wk[5]), .DEEP_WDT_TIMEOUT_IN(wk[6]),
		.VDD_LOST_IN(vdd_lost), .CPU_CLK_EN_OUT(cpu_en),
		.SYS_CLK_EN_OUT(sys_en), .PERIPH_CLK_EN_OUT(),
		.LOW_POWER_RC_EN_OUT(),
		.RAM_PWR_OUT(ram_pwr), .FLASH_PWR_OUT(), .LVR_ENGAGE_OUT(lvr_on),
		.IRQ_HOLD_OUT(), .WDT_CLEAR_OUT(), .WAKE_OUT(wake),
		.RESUME_RESET_OUT(resume), .DEEP_WDT_SELECT_OUT(deep_sleep_watchdog_sel),
		.MODE_OUT(mode));
	cpu_core_model cpu_core_model_i (.clk_in(clk), .instr_out(psave),
		.sleep_arg_out(sleep_arg));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ======================================================
	// tasks
	task end_of_test;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until ready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a slave that never answers counts as a mismatch
		cmp("bus ready", 32'h0000_0001, 32'(pready));
		rdat = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		cmp("read data", e, rdat);
	endtask
	// mode is looked at just after each edge has landed
	task settle(input logic [3:0] m);
		n = 0;
		#1;
		while (mode !== m && n < 9) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp("mode", 32'(m), 32'(mode));
	endtask
	task go(input logic arg, input logic [3:0] m);
		cpu_core_model_i.issue(arg);
		settle(m);
	endtask
	// wake sources are one-cycle pulses
	task pulse(input logic [6:0] m);
		@(posedge clk);
		wk <= m;
		@(posedge clk);
		wk <= 7'h00;
	endtask
	task woke(input logic rr);
		settle(4'h8);
		cmp("resume at reset", 32'(rr), 32'(resume));
	endtask

	// ======================================================
	// main sequence
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, lvr_cfg, vdd_lost, wk} = 12'h100;
		{paddr, pwdata} = 40'h00_0000_0000;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		settle(4'h0);
		cmp("cpu clock", 32'h0000_0001, 32'(cpu_en));
		for (int a = 0; a < 24; a += 4) rd(8'(a), 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		cmp("slave error", 32'h0000_0001, 32'(err));
		// lone writes, and a pair broken by another guarded write
		wr(OFF_GP_ZERO, 32'h0000_a5a5);
		rd(OFF_GP_ZERO, 32'h0000_0000);
		wr(OFF_GP_ZERO, 32'h0000_a5a5);
		rd(OFF_GP_ZERO, 32'h0000_a5a5);
		wr(OFF_GP_ONE, 32'h0000_1111);
		wr(OFF_DS_WAKE, 32'h0000_0001);
		wr(OFF_GP_ONE, 32'h0000_1111);
		rd(OFF_GP_ONE, 32'h0000_0000);
		rd(OFF_DS_WAKE, 32'h0000_0000);
		wr(OFF_GP_ONE, 32'h0000_2222);
		wr(OFF_GP_ONE, 32'h0000_2222);
		rd(OFF_GP_ONE, 32'h0000_2222);
		// idle, left by an interrupt and by a reset source
		go(1'b0, 4'h2);
		cmp("cpu clock", 32'h0000_0000, 32'(cpu_en));
		cmp("system clock", 32'h0000_0001, 32'(sys_en));
		pulse(7'h01);
		woke(1'b0);
		go(1'b0, 4'h2);
		pulse(7'h04);
		woke(1'b1);
		// single enable write gives plain sleep; interrupt held over entry
		wr(OFF_DS_CONTROL, 32'h0000_8000);
		fork
			cpu_core_model_i.issue(1'b1);
			begin
				@(posedge clk);
				wk <= 7'h01;
				repeat (2) @(posedge clk);
				wk <= 7'h00;
			end
		join
		settle(4'h3);
		woke(1'b0);
		// deep sleep, immune to interrupt and regular watchdog
		wr(OFF_DS_CONTROL, 32'h0000_8000);
		wr(OFF_DS_CONTROL, 32'h0000_8000);
		go(1'b1, 4'h5);
		cmp("ram power", 32'h0000_0000, 32'(ram_pwr));
		cmp("deep watchdog", 32'h0000_0001, 32'(deep_sleep_watchdog_sel));
		pulse(7'h21);
		settle(4'h5);
		pulse(7'h10);
		woke(1'b1);
		rd(OFF_GP_ZERO, 32'h0000_a5a5);
		// retention deep: the interrupt does not wake it, interrupt zero does
		wr(OFF_RESET_CONTROL, 32'h0000_1000);
		@(posedge clk);
		lvr_cfg <= 1'b0;
		go(1'b1, 4'h6);
		cmp("regulator", 32'h0000_0001, 32'(lvr_on));
		cmp("ram power", 32'h0000_0001, 32'(ram_pwr));
		pulse(7'h01);
		settle(4'h6);
		pulse(7'h02);
		woke(1'b0);
		// retention sleep, then the strap forbids the regulator
		wr(OFF_DS_CONTROL, 32'h0000_0000);
		wr(OFF_DS_CONTROL, 32'h0000_0000);
		go(1'b1, 4'h4);
		cmp("deep watchdog", 32'h0000_0000, 32'(deep_sleep_watchdog_sel));
		pulse(7'h20);
		woke(1'b0);
		@(posedge clk);
		lvr_cfg <= 1'b1;
		go(1'b1, 4'h3);
		cmp("regulator", 32'h0000_0000, 32'(lvr_on));
		pulse(7'h08);
		woke(1'b1);
		// battery mode keeps the retained registers
		@(posedge clk);
		vdd_lost <= 1'b1;
		settle(4'h7);
		@(posedge clk);
		vdd_lost <= 1'b0;
		woke(1'b1);
		rd(OFF_GP_ONE, 32'h0000_2222);
		end_of_test;
	end

	// hang guard, far beyond the few hundred cycles of the run
	initial begin
		repeat (4000) @(posedge clk);
		error_cnt++;
		end_of_test;
	end
endmodule
